// ---- design/sll_loader.sv ----
// Serial latch loader: 24-bit shift register on the serial clock, strobe
// transfer into four latches, monitor mux and power-down control.
// Assumes the serial clock runs only while the host shifts a word.
// Overview of operation
// - Each rising serial clock edge shifts the data pin into a 24-bit register.
// - A rising load strobe copies the shift register into a latch.
// - The low two shift register bits choose the one latch updated.
// - Monitor output shows lock detect, scaled feedback or scaled reference.
// - Chip enable low powers down and floats the charge pump output.
// - Chip enable high powers up only as the power-down bits allow.
// - Power-down opens the reference buffer and closes its bypass path.
// - Codes 00 control, 01 reference, 10 feedback, 11 test latch.
`default_nettype none
module sll_loader
  import sll_pkg::*;
(
  // System side
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // Serial link, sclk domain
  input  wire logic         sclk,
  input  wire logic         sdata,
  input  wire logic         load_strobe,
  // Pins sampled in the system domain
  input  wire logic         chip_enable,
  input  wire sll_mon_src_t mon_src,
  // Outputs
  output var  sll_latches_t latches,
  output var  logic         latch_update,
  output var  logic         band_select_start,
  output var  logic         monitor_output,
  output var  logic         charge_pump_en,
  output var  logic         ref_buf_connect,
  output var  logic         ref_bypass_closed,
  output var  logic         powered_up
);

  // Serial-clock domain: shift only
  logic [WORD_W-1:0] shift_q;

  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      shift_q <= LATCH_RST;
    end else begin
      shift_q <= {shift_q[WORD_W-2:0], sdata};
    end
  end

  // The strobe is only raised after the last edge, so the shift register is
  // static while the strobe is high and may be read as a quasi-static word.
  // Strobe edge is found in the system domain after a two-stage sync.
  logic [2:0] le_sync_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      le_sync_q <= 3'h0;
    end else begin
      le_sync_q <= {le_sync_q[1:0], load_strobe};
    end
  end

  logic le_rise;
  assign le_rise = le_sync_q[1] & ~le_sync_q[2];

  // Word capture: two system cycles after the strobe rises, the word is
  // stable so a plain sample of the held shift register is safe.
  logic [WORD_W-1:0] word_q;
  logic              word_vld_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      word_q     <= LATCH_RST;
      word_vld_q <= 1'b0;
    end else begin
      word_vld_q <= le_rise;
      if (le_rise) begin
        word_q <= shift_q;
      end
    end
  end

  sll_latch_sel_t sel;
  assign sel = sll_latch_sel_t'(word_q[SEL_LSB +: SEL_W]);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      latches           <= '0;
      latch_update      <= 1'b0;
      band_select_start <= 1'b0;
    end else begin
      latch_update      <= word_vld_q;
      band_select_start <= 1'b0;
      if (word_vld_q) begin
        unique case (sel)
          SLL_LATCH_CTRL: latches.ctrl   <= word_q;
          SLL_LATCH_REF:  latches.refdiv <= word_q;
          SLL_LATCH_FB: begin
            latches.fbdiv     <= word_q;
            band_select_start <= 1'b1;
          end
          SLL_LATCH_TEST: latches.test   <= word_q;
        endcase
      end
    end
  end

  // Pin synchronisers
  logic [1:0] ce_sync_q;
  logic [1:0] lock_sync_q;
  logic [1:0] fb_sync_q;
  logic [1:0] ref_sync_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ce_sync_q   <= 2'h0;
      lock_sync_q <= 2'h0;
      fb_sync_q   <= 2'h0;
      ref_sync_q  <= 2'h0;
    end else begin
      ce_sync_q   <= {ce_sync_q[0], chip_enable};
      lock_sync_q <= {lock_sync_q[0], mon_src.lock_detect};
      fb_sync_q   <= {fb_sync_q[0], mon_src.fb_scaled};
      ref_sync_q  <= {ref_sync_q[0], mon_src.ref_scaled};
    end
  end

  // Monitor multiplexer
  sll_mon_sel_t mon_sel;
  logic         mon_d;
  assign mon_sel = sll_mon_sel_t'(latches.ctrl[MON_LSB +: MON_W]);

  always_comb begin
    unique case (mon_sel)
      SLL_MON_LOCK:  mon_d = lock_sync_q[1];
      SLL_MON_FBDIV: mon_d = fb_sync_q[1];
      SLL_MON_REFDV: mon_d = ref_sync_q[1];
      SLL_MON_LOW:   mon_d = 1'b0;
      default:       mon_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      monitor_output <= 1'b0;
    end else begin
      monitor_output <= mon_d;
    end
  end

  // Power control: pin power-down overrides, software bits gate power-up
  logic pwr_d;
  assign pwr_d = ce_sync_q[1]
               & ~latches.ctrl[PD1_POS]
               & ~latches.ctrl[PD2_POS];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      powered_up        <= 1'b0;
      charge_pump_en    <= 1'b0;
      ref_buf_connect   <= 1'b0;
      ref_bypass_closed <= 1'b1;
    end else begin
      powered_up        <= pwr_d;
      charge_pump_en    <= pwr_d;
      ref_buf_connect   <= pwr_d;
      ref_bypass_closed <= ~pwr_d;
    end
  end

endmodule // sll_loader
`default_nettype wire

// ---- design/sll_pkg.sv ----
// Package for the serial latch loader: word layout, latch codes, monitor
// selection and reset values. Assumes a 24-bit three-wire write port.
`default_nettype none
package sll_pkg;
  localparam int          WORD_W      = 24;
  localparam int          SEL_LSB     = 0;
  localparam int          SEL_W       = 2;
  // Monitor select field position inside the control latch
  localparam int          MON_LSB     = 4;
  localparam int          MON_W       = 3;
  // Power-down bits inside the control latch
  localparam int          PD1_POS     = 20;
  localparam int          PD2_POS     = 21;
  localparam logic [23:0] LATCH_RST   = 24'h00_0000;

  typedef enum logic [1:0] {
    SLL_LATCH_CTRL = 2'b00,
    SLL_LATCH_REF  = 2'b01,
    SLL_LATCH_FB   = 2'b10,
    SLL_LATCH_TEST = 2'b11
  } sll_latch_sel_t;

  typedef enum logic [2:0] {
    SLL_MON_LOW   = 3'b000,
    SLL_MON_LOCK  = 3'b001,
    SLL_MON_FBDIV = 3'b010,
    SLL_MON_REFDV = 3'b100
  } sll_mon_sel_t;

  // Latched words as seen in the system domain
  typedef struct packed {
    logic [23:0] ctrl;
    logic [23:0] refdiv;
    logic [23:0] fbdiv;
    logic [23:0] test;
  } sll_latches_t;

  // Internal analog-side status levels fed to the monitor
  typedef struct packed {
    logic lock_detect;
    logic fb_scaled;
    logic ref_scaled;
  } sll_mon_src_t;
endpackage
`default_nettype wire

// ---- sim/sll_host.sv ----
// Host model driving the three-wire write port.
// Serial clock runs only inside a word, at a 12 ns period.
`default_nettype none
module sll_host (
  // Serial pins
  output var logic sclk,
  output var logic sdata,
  output var logic load_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    load_strobe = 1'b0;
  end
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      sdata = w[i];
      #6 sclk = 1'b1;
      #6 sclk = 1'b0;
    end
    // Released data line must not keep the last bit
    sdata = ~sdata;
    #20 load_strobe = 1'b1;
    #60 load_strobe = 1'b0;
    #40;
  endtask
endmodule // sll_host
`default_nettype wire

// ---- sim/sll_assertions.sv ----
// Output relations of the serial latch loader.
// Bound to every sll_loader; system clock domain only.
`default_nettype none
module sll_assertions
  import sll_pkg::*;
(
  // Clock and reset
  input wire logic         clk_sys,
  input wire logic         nrst,
  // Watched pins
  input wire logic         chip_enable,
  input wire logic         load_strobe,
  input wire sll_latches_t latches,
  input wire logic         latch_update,
  input wire logic         band_select_start,
  input wire logic         charge_pump_en,
  input wire logic         ref_buf_connect,
  input wire logic         ref_bypass_closed,
  input wire logic         powered_up
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Strobe passes two sync stages before the transfer
  sequence s_load; $rose(load_strobe); endsequence
  sequence s_done; ##[3:5] latch_update; endsequence
  AST_LOAD: assert property (s_load |-> s_done)
    else $error("no latch update after strobe");
  AST_WRITE: assert property ($changed(latches) |-> latch_update)
    else $error("latch changed without update");
  AST_PULSE: assert property (latch_update |=> !latch_update)
    else $error("update pulse too long");
  AST_BAND: assert property (band_select_start |->
    latch_update && latches.fbdiv[1:0] == 2'b10)
    else $error("band select without feedback write");
  AST_CE: assert property ($fell(chip_enable) |-> ##[2:4] !powered_up)
    else $error("no power down after enable low");
  AST_CP: assert property (!powered_up |-> !charge_pump_en)
    else $error("charge pump driven while down");
  AST_BYP: assert property (ref_bypass_closed != ref_buf_connect)
    else $error("bypass and buffer disagree");
  // Power-up is decided on the bits held one cycle before it shows
  AST_PD: assert property ($rose(powered_up) |->
    !$past(latches.ctrl[PD1_POS]) && !$past(latches.ctrl[PD2_POS]))
    else $error("power up against power-down bits");
endmodule // sll_assertions
bind sll_loader sll_assertions u_chk (.*);
`default_nettype wire

// ---- sim/sll_loader_bench.sv ----
// Bench for sll_loader: host model shifts words, rows check latches.
// Assumes sll_host and the bound checker are compiled alongside.
`default_nettype none
module sll_loader_bench
  import sll_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, nrst = 0, chip_enable = 0;
  sll_mon_src_t mon_src = '0;
  logic sclk, sdata, load_strobe, latch_update, band_select_start;
  logic monitor_output, charge_pump_en, ref_buf_connect;
  logic ref_bypass_closed, powered_up;
  sll_latches_t latches;
  logic [95:0] exp_q = '0;
  int errors = 0, checks = 0;
  int updates = 0, bands = 0;
  logic [23:0] rows [4] = '{24'h12_3451, 24'h00_0010, 24'hab_cde2,
                            24'h5a_5a5b};
  sll_loader dut (.*);
  sll_host host (.*);
  always #5 clk_sys = ~clk_sys;
  // Pulse counters for the update and band select outputs
  always @(posedge clk_sys) begin
    updates += int'(latch_update);
    bands += int'(band_select_start);
  end
  task automatic chk(input logic [95:0] got, want);
    checks++;
    if (got !== want) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic put(input logic [23:0] w);
    host.send(w);
    exp_q[95 - 24 * w[1:0] -: 24] = w;
    chk(latches, exp_q);
  endtask
  // Power, buffer and bypass state after the sync delay
  task automatic pwr(input logic [3:0] want, input logic ce);
    @(posedge clk_sys) chip_enable <= ce;
    repeat (5) @(posedge clk_sys);
    chk({powered_up, charge_pump_en, ref_buf_connect, ref_bypass_closed},
        want);
  endtask
  task automatic mon(input sll_mon_src_t s, input logic want);
    @(posedge clk_sys) mon_src <= s;
    repeat (5) @(posedge clk_sys);
    chk(monitor_output, want);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    pwr(4'b0001, 1'b0);
    foreach (rows[i]) put(rows[i]);
    mon(3'b100, 1'b1);
    put(24'h00_0040);
    mon(3'b100, 1'b0);
    mon(3'b001, 1'b1);
    put(24'h00_0020);
    mon(3'b010, 1'b1);
    mon(3'b101, 1'b0);
    put(24'h10_0010);
    pwr(4'b0001, 1'b1);
    put(24'h00_0010);
    pwr(4'b1110, 1'b1);
    put(24'h20_0010);
    pwr(4'b0001, 1'b1);
    put(24'h00_0010);
    pwr(4'b0001, 1'b0);
    @(posedge clk_sys) nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(latches, '0);
    @(posedge clk_sys) nrst <= 1'b1;
    exp_q = '0;
    put(24'h00_0102);
    chk(updates, 11);
    chk(bands, 2);
    end_of_test();
  end
endmodule // sll_loader_bench
`default_nettype wire
